// *** hw/rmc_recorder_ctrl.sv ***
`timescale 1ns/1ps
`include "rmc_cfg.svh"
module rmc_recorder_ctrl #(
  parameter logic [31:0] HOLD_CYC =
    32'(`RMC_HOLD_S * `RMC_CLK_MHZ * 1000000),
  parameter logic [31:0] DEB_CYC  =
    32'(`RMC_DEB_MS * `RMC_CLK_MHZ * 1000)
) (
  input  wire logic                   pclk,        // bus clock
  input  wire logic                   presetn,     // async reset
  input  wire logic                   psel,        // apb select
  input  wire logic                   penable,     // apb enable
  input  wire logic                   pwrite,      // apb direction
  input  wire logic [`RMC_ADDR_W-1:0] paddr,       // apb address
  input  wire logic [31:0]            pwdata,      // apb write data
  output logic      [31:0]            prdata,      // apb read data
  output logic                        pready,      // apb ready
  output logic                        pslverr,     // apb error
  output logic                        irq,         // interrupt level
  input  wire logic                   btn_pin,     // record button
  input  wire logic                   med_present, // medium inserted
  input  wire logic                   nv_rec_in,   // saved record flag
  output logic                        nv_rec,      // record flag to save
  input  wire logic                   rx_valid,    // byte received
  input  wire logic                   rx_err,      // misframed char
  input  wire logic [7:0]             rx_data,     // received byte
  output logic                        sto_req,     // storage request
  output logic      [1:0]             sto_op,      // storage operation
  output logic      [7:0]             sto_byte,    // byte to append
  input  wire logic                   sto_done,    // request finished
  input  wire logic                   sto_ok,      // finished well
  input  wire logic                   sto_full,    // partition full
  output logic                        rec_led,     // record indicator
  output logic                        data_led,    // data indicator
  output logic                        flash_led    // restore pattern
);
  localparam rmc_pkg::rmc_regs_t RST = '{
    state:    rmc_pkg::ST_BOOT,
    sto_op:   rmc_pkg::OP_OPEN,
    name:     {`RMC_NAMEHI_RST, `RMC_NAMELO_RST},
    default:  '0
  };

  rmc_pkg::rmc_regs_t    r;
  rmc_pkg::rmc_regs_t    n;
  logic                  press;
  logic                  done;
  logic                  wr;
  logic [`RMC_INT_W-1:0] ev;
  logic [`RMC_INT_W-1:0] clr;

  function automatic logic f_mapped(input logic [`RMC_ADDR_W-1:0] a);
    f_mapped = (a == `RMC_A_CTRL) || (a == `RMC_A_STAT) ||
               (a == `RMC_A_ISTAT) || (a == `RMC_A_IMASK) ||
               (a == `RMC_A_NAMELO) || (a == `RMC_A_NAMEHI);
  endfunction

  // char 0 leftmost in bits 7:0, char 7 rightmost in bits 63:56
  function automatic logic [63:0] f_next_name(input logic [63:0] nm);
    logic [63:0] o;
    logic        pad;
    logic        cy;
    logic [7:0]  c;
    o = nm;
    pad = 1'b0;
    cy = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (o[8*i +: 8] == 8'h00) begin
        pad = 1'b1;
      end
      if (pad) begin
        o[8*i +: 8] = 8'h30;
      end
    end
    for (int i = 7; i >= 0; i--) begin
      c = o[8*i +: 8];
      if (cy) begin
        if (c == 8'h39) begin
          o[8*i +: 8] = 8'h41;
          cy = 1'b0;
        end else if (c == 8'h5a) begin
          o[8*i +: 8] = 8'h30;
        end else begin
          o[8*i +: 8] = c + 8'h01;
          cy = 1'b0;
        end
      end
    end
    f_next_name = o;
  endfunction

  always_comb begin
    n = r;
    ev = '0;
    clr = '0;
    press = 1'b0;
    done = r.sto_req & sto_done;
    wr = psel & penable & r.pready & pwrite;
    n.bsync = {r.bsync[1:0], btn_pin};
    n.msync = {r.msync[1:0], med_present};
    n.data_led = rx_valid | rx_err;
    if (done) begin
      n.sto_req = 1'b0;
    end
    // debounce: level must agree and hold before it counts
    n.deb_cnt = 32'h0;
    if (r.bsync[2] == r.bsync[1] && r.bsync[2] != r.btn_db) begin
      n.deb_cnt = r.deb_cnt + 32'h1;
      if (r.deb_cnt == DEB_CYC - 32'h1) begin
        n.btn_db = r.bsync[2];
        press = r.bsync[2];
        n.deb_cnt = 32'h0;
      end
    end
    // apb: one wait state, data and ready registered together
    n.pready = psel & penable & ~r.pready;
    n.pslverr = 1'b0;
    n.prdata = 32'h0;
    if (psel & penable & ~r.pready) begin
      n.pslverr = ~f_mapped(paddr);
      case (paddr)
        `RMC_A_CTRL:   n.prdata = {29'h0, r.locked, r.ovwr, r.append};
        `RMC_A_STAT:   n.prdata = {22'h0, r.factory, r.pend, r.nv_rec,
                                   r.state};
        `RMC_A_ISTAT:  n.prdata = {27'h0, r.int_stat};
        `RMC_A_IMASK:  n.prdata = {27'h0, r.int_mask};
        `RMC_A_NAMELO: n.prdata = r.name[31:0];
        `RMC_A_NAMEHI: n.prdata = r.name[63:32];
        default:       n.prdata = 32'h0;
      endcase
    end
    if (wr) begin
      // settings frozen once the loader locks them
      if (paddr == `RMC_A_CTRL && !r.locked) begin
        n.append = pwdata[`RMC_B_APPEND];
        n.ovwr = pwdata[`RMC_B_OVWR];
        n.locked = pwdata[`RMC_B_LOCK];
      end
      if (paddr == `RMC_A_NAMELO && !r.locked) begin
        n.name[31:0] = pwdata;
      end
      if (paddr == `RMC_A_NAMEHI && !r.locked) begin
        n.name[63:32] = pwdata;
      end
      if (paddr == `RMC_A_ISTAT) begin
        clr = pwdata[`RMC_INT_W-1:0];
      end
      if (paddr == `RMC_A_IMASK) begin
        n.int_mask = pwdata[`RMC_INT_W-1:0];
      end
    end
    unique case (r.state)
      rmc_pkg::ST_BOOT: begin
        n.hold_cnt = r.hold_cnt + 32'h1;
        if (r.hold_cnt == `RMC_SETTLE) begin
          n.hold_cnt = 32'h0;
          n.resume = nv_rec_in;
          n.btn_db = r.bsync[2];
          if (!r.msync[2] && !r.msync[1] && r.bsync[2] && r.bsync[1]) begin
            n.state = rmc_pkg::ST_HOLD;
          end else begin
            n.state = rmc_pkg::ST_STOP;
          end
        end
      end
      rmc_pkg::ST_HOLD: begin
        n.hold_cnt = r.hold_cnt + 32'h1;
        if (!r.bsync[2] && !r.bsync[1]) begin
          n.state = rmc_pkg::ST_STOP;
        end else if (r.hold_cnt == HOLD_CYC - 32'h1) begin
          n.append = 1'b0;
          n.ovwr = 1'b0;
          n.name = {`RMC_NAMEHI_RST, `RMC_NAMELO_RST};
          n.factory = 1'b1;
          n.flash_led = 1'b1;
          n.state = rmc_pkg::ST_STOP;
        end
      end
      rmc_pkg::ST_STOP: begin
        if (press || (r.resume && r.locked)) begin
          n.state = rmc_pkg::ST_OPEN;
          n.sto_req = 1'b1;
          n.sto_op = rmc_pkg::OP_OPEN;
          n.resume = 1'b0;
          n.flash_led = 1'b0;
          n.pend = 1'b0;
        end
      end
      rmc_pkg::ST_OPEN: begin
        if (done && sto_ok) begin
          n.state = rmc_pkg::ST_REC;
          n.rec_led = 1'b1;
          n.nv_rec = 1'b1;
          ev[`RMC_I_START] = 1'b1;
        end else if (done) begin
          n.state = rmc_pkg::ST_STOP;
          ev[`RMC_I_FAIL] = 1'b1;
        end
      end
      rmc_pkg::ST_REC: begin
        if (press) begin
          n.state = rmc_pkg::ST_CLOSE;
        end else if (!r.sto_req && sto_full) begin
          ev[`RMC_I_FULL] = 1'b1;
          if (r.ovwr) begin
            n.state = rmc_pkg::ST_DEL;
            n.sto_req = 1'b1;
            n.sto_op = rmc_pkg::OP_DEL;
          end else begin
            n.state = rmc_pkg::ST_CLOSE;
          end
        end else if (!r.sto_req && r.pend) begin
          n.sto_req = 1'b1;
          n.sto_op = rmc_pkg::OP_WRITE;
          n.sto_byte = r.pend_byte;
          n.pend = 1'b0;
        end
      end
      rmc_pkg::ST_DEL: begin
        if (done) begin
          n.state = sto_ok ? rmc_pkg::ST_REC : rmc_pkg::ST_CLOSE;
        end
      end
      rmc_pkg::ST_CLOSE: begin
        // drain the held byte before the close goes out
        if (!r.sto_req) begin
          n.sto_req = 1'b1;
          n.sto_op = r.pend ? rmc_pkg::OP_WRITE : rmc_pkg::OP_CLOSE;
          n.sto_byte = r.pend_byte;
          n.pend = 1'b0;
        end
        if (done && r.sto_op == rmc_pkg::OP_CLOSE) begin
          n.state = rmc_pkg::ST_STOP;
          n.rec_led = 1'b0;
          n.nv_rec = 1'b0;
          ev[`RMC_I_STOP] = 1'b1;
          if (!r.append) begin
            n.name = f_next_name(r.name);
          end
        end
      end
    endcase
    // single holding byte: a second byte before issue is an overrun
    if (rx_valid && r.state == rmc_pkg::ST_REC) begin
      if (n.pend) begin
        ev[`RMC_I_OVRUN] = 1'b1;
      end else begin
        n.pend = 1'b1;
        n.pend_byte = rx_data;
      end
    end
    n.int_stat = (r.int_stat & ~clr) | ev;
    n.irq = |(n.int_stat & n.int_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign irq       = r.irq;
  assign nv_rec    = r.nv_rec;
  assign sto_req   = r.sto_req;
  assign sto_op    = r.sto_op;
  assign sto_byte  = r.sto_byte;
  assign rec_led   = r.rec_led;
  assign data_led  = r.data_led;
  assign flash_led = r.flash_led;

  property p_lock;
    @(posedge pclk) disable iff (!presetn)
    r.locked && r.state != rmc_pkg::ST_HOLD |=>
      $stable(r.append) && $stable(r.ovwr);
  endproperty
  a_lock: assert property (p_lock) else $error("settings moved");

  property p_open;
    @(posedge pclk) disable iff (!presetn)
    $rose(r.rec_led) |->
      $past(r.state == rmc_pkg::ST_OPEN && done && sto_ok);
  endproperty
  a_open: assert property (p_open) else $error("led before open");

  property p_write;
    @(posedge pclk) disable iff (!presetn)
    r.state == rmc_pkg::ST_REC && !press && !sto_full && r.pend &&
      !r.sto_req |=> r.sto_req && r.sto_op == rmc_pkg::OP_WRITE &&
      r.sto_byte == $past(r.pend_byte);
  endproperty
  a_write: assert property (p_write) else $error("byte not sent");

  property p_data;
    @(posedge pclk) disable iff (!presetn)
    rx_err |=> r.data_led ##1 (r.data_led == $past(rx_valid | rx_err));
  endproperty
  a_data: assert property (p_data) else $error("data led wrong");

  property p_close;
    @(posedge pclk) disable iff (!presetn)
    r.state == rmc_pkg::ST_CLOSE && done &&
      r.sto_op == rmc_pkg::OP_CLOSE |=>
      r.state == rmc_pkg::ST_STOP && !r.rec_led && !r.nv_rec;
  endproperty
  a_close: assert property (p_close) else $error("close not done");

  property p_resume;
    @(posedge pclk) disable iff (!presetn)
    r.state == rmc_pkg::ST_STOP && r.resume && r.locked |=>
      r.state == rmc_pkg::ST_OPEN ##[1:1000] r.state != rmc_pkg::ST_OPEN;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume");

  property p_name;
    @(posedge pclk) disable iff (!presetn)
    r.state == rmc_pkg::ST_CLOSE && done && !r.append &&
      r.sto_op == rmc_pkg::OP_CLOSE |=> r.name != $past(r.name);
  endproperty
  a_name: assert property (p_name) else $error("name reused");

  property p_full;
    @(posedge pclk) disable iff (!presetn)
    r.state == rmc_pkg::ST_REC && !press && !r.sto_req && sto_full |=>
      r.state == (r.ovwr ? rmc_pkg::ST_DEL : rmc_pkg::ST_CLOSE);
  endproperty
  a_full: assert property (p_full) else $error("full missed");

  property p_fail;
    @(posedge pclk) disable iff (!presetn)
    r.state == rmc_pkg::ST_OPEN && done && !sto_ok |=>
      r.state == rmc_pkg::ST_STOP && !r.rec_led;
  endproperty
  a_fail: assert property (p_fail) else $error("bad open");
endmodule

// *** hw/rmc_cfg.svh ***
`ifndef RMC_CFG_SVH
`define RMC_CFG_SVH
`define RMC_ADDR_W    8
`define RMC_A_CTRL    8'h00
`define RMC_A_STAT    8'h04
`define RMC_A_ISTAT   8'h08
`define RMC_A_IMASK   8'h0c
`define RMC_A_NAMELO  8'h10
`define RMC_A_NAMEHI  8'h14
`define RMC_B_APPEND  0
`define RMC_B_OVWR    1
`define RMC_B_LOCK    2
`define RMC_INT_W     5
`define RMC_I_START   0
`define RMC_I_STOP    1
`define RMC_I_FAIL    2
`define RMC_I_FULL    3
`define RMC_I_OVRUN   4
`define RMC_NAMELO_RST 32'h2d524453
`define RMC_NAMEHI_RST 32'h30303030
`define RMC_CLK_MHZ   250
`define RMC_HOLD_S    5
`define RMC_DEB_MS    10
`define RMC_SETTLE    32'h00000003
`endif

// *** hw/rmc_pkg.sv ***
`include "rmc_cfg.svh"
package rmc_pkg;
  typedef enum logic [6:0] {
    ST_BOOT  = 7'h01,
    ST_HOLD  = 7'h02,
    ST_STOP  = 7'h04,
    ST_OPEN  = 7'h08,
    ST_REC   = 7'h10,
    ST_CLOSE = 7'h20,
    ST_DEL   = 7'h40
  } rmc_state_t;

  typedef enum logic [1:0] {
    OP_OPEN  = 2'h0,
    OP_WRITE = 2'h1,
    OP_CLOSE = 2'h2,
    OP_DEL   = 2'h3
  } rmc_op_t;

  typedef struct packed {
    rmc_state_t            state;
    logic [2:0]            bsync;
    logic [2:0]            msync;
    logic                  btn_db;
    logic [31:0]           deb_cnt;
    logic [31:0]           hold_cnt;
    logic                  append;
    logic                  ovwr;
    logic                  locked;
    logic                  factory;
    logic                  resume;
    logic [63:0]           name;
    logic                  pend;
    logic [7:0]            pend_byte;
    logic [`RMC_INT_W-1:0] int_stat;
    logic [`RMC_INT_W-1:0] int_mask;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic                  rec_led;
    logic                  data_led;
    logic                  flash_led;
    logic                  irq;
    logic                  sto_req;
    rmc_op_t               sto_op;
    logic [7:0]            sto_byte;
    logic                  nv_rec;
  } rmc_regs_t;
endpackage

// *** verification/rmc_store_model.sv ***
`timescale 1ns/1ps
module rmc_store_model (
  input  wire logic       pclk,      // bus clock
  input  wire logic       presetn,   // async reset
  input  wire logic       sto_req,   // request level
  input  wire logic [1:0] sto_op,    // requested operation
  input  wire logic [7:0] sto_byte,  // byte to append
  input  wire logic       fail_open, // bench orders an open refusal
  input  wire logic [3:0] lat,       // answer delay in cycles
  output logic            sto_done,  // completion pulse
  output logic            sto_ok     // result, valid with done
);
  logic [7:0] log_q[$];
  logic [1:0] ops_q[$];
  logic [3:0] wait_cnt;
  logic       busy;
  logic       answered;
  logic       ok_val;
  logic       junk;

  // ok is only meaningful with done; toggle otherwise so nothing leans on it
  assign sto_ok = sto_done ? ok_val : junk;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sto_done <= 1'b0;
      busy     <= 1'b0;
      answered <= 1'b0;
      wait_cnt <= 4'h0;
      ok_val   <= 1'b0;
      junk     <= 1'b0;
      log_q.delete();
      ops_q.delete();
    end else begin
      junk     <= ~junk;
      sto_done <= 1'b0;
      if (!busy && sto_req) begin
        busy     <= 1'b1;
        wait_cnt <= lat;
      end else if (busy && !answered && wait_cnt != 4'h0) begin
        wait_cnt <= wait_cnt - 4'h1;
      end else if (busy && !answered) begin
        sto_done <= 1'b1;
        answered <= 1'b1;
        ok_val   <= !(fail_open && sto_op == 2'h0);
        ops_q.push_back(sto_op);
        if (sto_op == 2'h1) begin
          log_q.push_back(sto_byte);
        end
      end else if (answered && !sto_req) begin
        busy     <= 1'b0;
        answered <= 1'b0;
      end
    end
  end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
`include "rmc_cfg.svh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        btn_pin, med_present, nv_rec_in, nv_rec, rx_valid, rx_err;
  logic        sto_req, sto_done, sto_ok, sto_full, fail_open;
  logic        rec_led, data_led, flash_led;
  logic [1:0]  sto_op;
  logic [7:0]  paddr, rx_data, sto_byte;
  logic [31:0] pwdata, prdata, r;
  int          n_errors, comparisons;

  rmc_recorder_ctrl #(.HOLD_CYC(32'h32), .DEB_CYC(32'h4)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .btn_pin, .med_present, .nv_rec_in, .nv_rec,
    .rx_valid, .rx_err, .rx_data, .sto_req, .sto_op, .sto_byte, .sto_done,
    .sto_ok, .sto_full, .rec_led, .data_led, .flash_led);

  rmc_store_model m (.pclk, .presetn, .sto_req, .sto_op, .sto_byte,
    .fail_open, .lat(4'h2), .sto_done, .sto_ok);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic test_done();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one transfer; a spare edge after release keeps psel from toggling twice
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = wr ? {31'h0, pslverr} : prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  task automatic press();
    btn_pin <= 1'b1;
    repeat (16) @(posedge pclk);
    btn_pin <= 1'b0;
    repeat (16) @(posedge pclk);
  endtask

  task automatic wait_rec(input logic v);
    int n;
    n = 0;
    while (rec_led !== v && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, rec_led}, {31'h0, v});
  endtask

  task automatic wait_op(input logic [1:0] op);
    int n;
    n = 0;
    while (!(m.ops_q.size() > 0 && m.ops_q[$] === op) && n < 300) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // data led is a one-cycle pulse seen one edge after the strobe
  task automatic send(input logic [7:0] d, input logic bad);
    rx_valid <= !bad;
    rx_err   <= bad;
    rx_data  <= d;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_err   <= 1'b0;
    @(posedge pclk);
    chk({31'h0, data_led}, 32'h1);
    repeat (10) @(posedge pclk);
  endtask

  task automatic power_up(input logic nv);
    presetn   <= 1'b0;
    nv_rec_in <= nv;
    repeat (20) @(posedge pclk);
    presetn   <= 1'b1;
    repeat (10) @(posedge pclk);
  endtask

  initial begin
    {psel, penable, pwrite, btn_pin, rx_valid, rx_err} = 6'h0;
    {nv_rec_in, sto_full, fail_open, presetn} = 4'h0;
    {paddr, rx_data, pwdata} = 48'h0;
    med_present = 1'b1;
    power_up(1'b0);
    rd_chk(`RMC_A_CTRL, 32'h0);
    rd_chk(`RMC_A_NAMELO, `RMC_NAMELO_RST);
    rd_chk(`RMC_A_NAMEHI, `RMC_NAMEHI_RST);
    apb(1'b0, 8'h3c, 32'h0, r);
    chk(r, 32'h0);
    // error flag only stands with ready, so take it inside the transfer
    apb(1'b1, 8'h3c, 32'h0, r);
    chk(r, 32'h1);
    wr(`RMC_A_IMASK, 32'h1f);
    wr(`RMC_A_CTRL, 32'h4);
    wr(`RMC_A_CTRL, 32'h3);
    rd_chk(`RMC_A_CTRL, 32'h4);
    press();
    wait_rec(1'b1);
    chk(32'(m.ops_q[0]), 32'(rmc_pkg::OP_OPEN));
    rd_chk(`RMC_A_STAT, 32'h90);
    chk({31'h0, irq}, 32'h1);
    for (int i = 0; i < 4; i++) send(8'h41 + 8'(i), i == 2);
    chk(m.log_q.size(), 3);
    foreach (m.log_q[i])
      chk(m.log_q[i], 8'h41 + 8'(i > 1 ? i + 1 : i));
    press();
    wait_rec(1'b0);
    chk(32'(m.ops_q[$]), 32'(rmc_pkg::OP_CLOSE));
    rd_chk(`RMC_A_STAT, 32'h4);
    rd_chk(`RMC_A_NAMEHI, 32'h31303030);
    rd_chk(`RMC_A_ISTAT, 32'h3);
    wr(`RMC_A_ISTAT, 32'h3);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    fail_open <= 1'b1;
    press();
    repeat (60) @(posedge pclk);
    chk({31'h0, rec_led}, 32'h0);
    rd_chk(`RMC_A_STAT, 32'h4);
    apb(1'b0, `RMC_A_ISTAT, 32'h0, r);
    chk(r & 32'h4, 32'h4);
    rd_chk(`RMC_A_CTRL, 32'h4);
    fail_open <= 1'b0;
    press();
    wait_rec(1'b1);
    sto_full <= 1'b1;
    wait_rec(1'b0);
    chk(32'(m.ops_q[$]), 32'(rmc_pkg::OP_CLOSE));
    sto_full <= 1'b0;
    apb(1'b0, `RMC_A_ISTAT, 32'h0, r);
    chk(r & 32'h8, 32'h8);
    power_up(1'b0);
    wr(`RMC_A_CTRL, 32'h7);
    press();
    wait_rec(1'b1);
    send(8'h5a, 1'b0);
    sto_full <= 1'b1;
    wait_op(rmc_pkg::OP_DEL);
    sto_full <= 1'b0;
    repeat (30) @(posedge pclk);
    chk(32'(m.ops_q[$]), 32'(rmc_pkg::OP_DEL));
    chk({31'h0, rec_led}, 32'h1);
    chk({31'h0, nv_rec}, 32'h1);
    power_up(1'b1);
    wr(`RMC_A_CTRL, 32'h7);
    wait_rec(1'b1);
    press();
    wait_rec(1'b0);
    rd_chk(`RMC_A_NAMEHI, `RMC_NAMEHI_RST);
    // no medium, button held through power-up: settings written during
    // the hold must be thrown away when the restore fires
    med_present <= 1'b0;
    btn_pin     <= 1'b1;
    power_up(1'b0);
    wr(`RMC_A_NAMELO, 32'h11223344);
    wr(`RMC_A_CTRL, 32'h3);
    repeat (60) @(posedge pclk);
    chk({31'h0, flash_led}, 32'h1);
    rd_chk(`RMC_A_STAT, 32'h204);
    rd_chk(`RMC_A_CTRL, 32'h0);
    rd_chk(`RMC_A_NAMELO, `RMC_NAMELO_RST);
    btn_pin     <= 1'b0;
    repeat (30) @(posedge pclk);
    chk({31'h0, rec_led}, 32'h0);
    test_done();
  end

  // whole sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    test_done();
  end
endmodule
